// [rtl/locality_request_and_status_fsm.sv]
`timescale 1ns/1ps
module locality_request_and_status_fsm (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire locality_pkg::axil_req_type axiReq,
  output      locality_pkg::axil_rsp_type axiRsp,
  input  wire logic                       cmdByteWrite,
  input  wire logic                       execDone,
  input  wire logic                       cmdExpect,
  input  wire logic                       fieldsSettled,
  input  wire logic                       launchFinish,
  input  wire logic                       nvLaunchFlag,
  output      logic                       nvWrite,
  output      logic                       nvData,
  output      logic                       abortCmd,
  output      logic                       freeResources,
  output      logic [2:0]                 activeLoc
);
  import locality_pkg::*;

  typedef struct packed {
    axil_rsp_type        rsp;
    logic                awHeld;
    logic [ADDR_W-1:0]   awAddr;
    logic                wHeld;
    logic [31:0]         wData;
    logic [NUM_LOC-1:0]  useReq;
    logic [2:0]          active;
    logic                launchFlag;
    logic                regValid;
    cmd_state_type       fsm;
    logic                status_fields_valid;
    logic                nvWrite;
    logic                nvData;
    logic                abortCmd;
    logic                freeRes;
  } core_type;

  localparam core_type CORE_RESET = '{
    rsp: '0, awHeld: 1'b0, awAddr: '0, wHeld: 1'b0, wData: '0,
    useReq: '0, active: LOC_NONE, launchFlag: 1'b0, regValid: 1'b0,
    fsm: ST_IDLE, status_fields_valid: 1'b0, nvWrite: 1'b0, nvData: 1'b0,
    abortCmd: 1'b0, freeRes: 1'b0};

  core_type s_r;
  core_type s_nxt;

  logic        wrFire;
  logic [2:0]  wrLoc;
  logic        wrAcc;
  logic        wrSts;
  logic [31:0] wrData;
  logic        wrOneHot;
  logic        clearFire;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ACC_BASE;
    decode = 4'hF;
    if (a[1:0] == 2'h0) begin
      if (a >= ACC_BASE && a < ACC_BASE + ADDR_W'(4 * NUM_LOC)) begin
        decode = {1'b0, off[4:2]};
      end else if (a >= STS_BASE && a < STS_BASE + ADDR_W'(4 * NUM_LOC)) begin
        off = a - STS_BASE;
        decode = {1'b1, off[4:2]};
      end
    end
  endfunction : decode

  logic [3:0] wrDec;
  assign wrDec    = decode(s_r.awAddr);
  assign wrFire   = s_r.awHeld && s_r.wHeld && !s_r.rsp.bvalid;
  assign wrLoc    = wrDec[2:0];
  assign wrAcc    = wrFire && wrDec != 4'hF && !wrDec[3];
  assign wrSts    = wrFire && wrDec != 4'hF && wrDec[3];
  assign wrData   = s_r.wData;
  assign wrOneHot = $countones(wrData) == 1;
  // Launch flag may be restored only from the privileged localities
  assign clearFire = wrSts && wrOneHot && s_r.active == wrLoc
                     && wrData[STS_CLEAR] && wrLoc >= LOC_LAUNCH;

  always_comb begin
    logic [3:0]  rdDec;
    logic [2:0]  rdLoc;
    logic [31:0] rv;
    s_nxt = s_r;
    rdDec = decode(axiReq.araddr);
    rdLoc = rdDec[2:0];
    rv    = '0;
    s_nxt.nvWrite  = 1'b0;
    s_nxt.abortCmd = 1'b0;
    s_nxt.freeRes  = 1'b0;
    s_nxt.status_fields_valid = fieldsSettled;

    if (axiReq.awvalid && s_r.rsp.awready) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s_r.rsp.wready) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = axiReq.wdata & lane_mask(axiReq.wstrb);
    end
    if (s_r.rsp.bvalid && axiReq.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end

    // Restore the launch flag once after reset; valid stays low till then
    if (!s_r.regValid) begin
      s_nxt.launchFlag = nvLaunchFlag;
      s_nxt.regValid   = 1'b1;
    end

    if (wrFire) begin
      s_nxt.awHeld     = 1'b0;
      s_nxt.wHeld      = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp  = (wrDec == 4'hF) ? RESP_SLVERR : RESP_OKAY;
    end

    if (wrAcc) begin
      if (wrData[ACC_GRANTED]) begin
        if (s_r.active == wrLoc) begin
          s_nxt.active = LOC_NONE;
          s_nxt.fsm    = ST_IDLE;
        end else if (s_r.useReq[wrLoc]) begin
          s_nxt.useReq[wrLoc] = 1'b0;
        end
      end else if (wrData[ACC_REQUEST] && !s_r.useReq[wrLoc]
                   && s_r.active != wrLoc) begin
        s_nxt.useReq[wrLoc] = 1'b1;
      end
    end

    // Writes from other localities never touch the shared machine
    if (wrSts && wrOneHot && s_r.active == wrLoc) begin
      if (wrData[STS_READY]) begin
        unique case (s_r.fsm)
          ST_IDLE:  s_nxt.fsm = ST_READY;
          ST_EXEC: begin
            s_nxt.fsm      = ST_IDLE;
            s_nxt.abortCmd = 1'b1;
          end
          ST_DONE: begin
            s_nxt.fsm     = ST_IDLE;
            s_nxt.freeRes = 1'b1;
          end
          ST_READY, ST_RECV: s_nxt.fsm = s_r.fsm;
        endcase
      end
      if (wrData[STS_GO] && s_r.fsm == ST_RECV) begin
        s_nxt.fsm = ST_EXEC;
      end
    end

    if (clearFire) begin
      s_nxt.launchFlag = 1'b1;
      s_nxt.nvWrite    = 1'b1;
      s_nxt.nvData     = 1'b1;
    end
    // Launch finish wins over a clear in the same cycle
    if (launchFinish && s_r.regValid) begin
      s_nxt.launchFlag = 1'b0;
      s_nxt.nvWrite    = 1'b1;
      s_nxt.nvData     = 1'b0;
    end

    if (cmdByteWrite && s_r.fsm == ST_READY) begin
      s_nxt.fsm = ST_RECV;
    end
    if (execDone && s_r.fsm == ST_EXEC && s_nxt.fsm == ST_EXEC) begin
      s_nxt.fsm = ST_DONE;
    end

    // Highest locality wins when control is free
    if (s_nxt.active == LOC_NONE) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        if (s_nxt.useReq[i]) begin
          s_nxt.active = 3'(i);
        end
      end
      if (s_nxt.active != LOC_NONE) begin
        s_nxt.useReq[s_nxt.active] = 1'b0;
        s_nxt.fsm = ST_IDLE;
      end
    end

    if (rdDec != 4'hF && !rdDec[3]) begin
      rv[ACC_LAUNCH]  = s_r.regValid & s_r.launchFlag;
      rv[ACC_REQUEST] = s_r.useReq[rdLoc];
      rv[ACC_GRANTED] = s_r.active == rdLoc;
      rv[ACC_VALID]   = s_r.regValid;
    end else if (rdDec != 4'hF) begin
      // Zero wait states: every plain field is a flop, always true
      rv[STS_FVALID]  = s_r.status_fields_valid;
      rv[STS_READY]   = s_r.fsm == ST_READY;
      rv[STS_PENDING] = s_r.status_fields_valid && s_r.fsm == ST_DONE;
      rv[STS_EXPECT]  = s_r.status_fields_valid && cmdExpect && s_r.fsm == ST_RECV;
    end
    if (axiReq.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata  = rv;
      s_nxt.rsp.rresp  = (rdDec == 4'hF) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_r.rsp.rvalid && axiReq.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end

    s_nxt.rsp.awready = !s_nxt.awHeld;
    s_nxt.rsp.wready  = !s_nxt.wHeld;
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= CORE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axiRsp        = s_r.rsp;
  assign nvWrite       = s_r.nvWrite;
  assign nvData        = s_r.nvData;
  assign abortCmd      = s_r.abortCmd;
  assign freeResources = s_r.freeRes;
  assign activeLoc     = s_r.active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_go_taken;
    wrSts && wrOneHot && s_r.active == wrLoc && wrData[STS_GO]
      && s_r.fsm == ST_RECV;
  endsequence

  sequence s_ready_cmd;
    wrSts && wrOneHot && s_r.active == wrLoc && wrData[STS_READY];
  endsequence

  // An abort write in the same cycle would win, so it is left out
  sequence s_exec_done;
    execDone && s_r.fsm == ST_EXEC && !wrFire;
  endsequence

  a_zero_write_kept: assert property (
    wrAcc && !wrData[ACC_REQUEST] && !wrData[ACC_GRANTED]
      && s_r.active != LOC_NONE
    |=> s_r.useReq == $past(s_r.useReq))
    else $error("zero write changed a use request");

  a_request_sets: assert property (
    wrAcc && wrData[ACC_REQUEST] && !wrData[ACC_GRANTED]
      && s_r.active != wrLoc && s_r.active != LOC_NONE
    |=> s_r.useReq[$past(wrLoc)])
    else $error("use request not set");

  a_grant_clears: assert property (
    $changed(s_r.active) && s_r.active != LOC_NONE
    |-> !s_r.useReq[s_r.active] && s_r.fsm == ST_IDLE)
    else $error("granted locality kept its request");

  a_cancel_clears: assert property (
    wrAcc && wrData[ACC_GRANTED] && s_r.active != wrLoc
      && s_r.useReq[wrLoc]
    |=> !s_r.useReq[$past(wrLoc)])
    else $error("cancel left request set");

  a_release_drops: assert property (
    wrAcc && wrData[ACC_GRANTED] && s_r.active == wrLoc
    |=> s_r.active != $past(wrLoc))
    else $error("active locality kept control");

  a_finish_clears: assert property (
    launchFinish && s_r.regValid
    |=> !s_r.launchFlag && s_r.nvWrite && !s_r.nvData)
    else $error("launch flag not cleared");

  a_flag_held_low: assert property (
    s_r.regValid && !s_r.launchFlag && !clearFire
    |=> !s_r.launchFlag)
    else $error("launch flag rose without clear");

  a_multi_discard: assert property (
    wrSts && !wrOneHot && !launchFinish && !execDone && !cmdByteWrite
      && s_nxt.active == s_r.active
    |=> $stable(s_r.fsm) && $stable(s_r.launchFlag))
    else $error("multi-bit status write took effect");

  a_exec_path: assert property (
    s_go_taken |=> s_r.fsm == ST_EXEC)
    else $error("execute trigger did not start execution");

  a_done_entry: assert property (
    s_exec_done |=> s_r.fsm == ST_DONE)
    else $error("execution did not complete");

  a_ready_entry: assert property (
    s_ready_cmd and (s_r.fsm == ST_IDLE && s_nxt.active == s_r.active)
    |=> s_r.fsm == ST_READY)
    else $error("idle did not become ready");

  a_abort_exec: assert property (
    s_ready_cmd and (s_r.fsm == ST_EXEC)
    |=> s_r.fsm == ST_IDLE && s_r.abortCmd)
    else $error("abort did not return to idle");

endmodule : locality_request_and_status_fsm

// [rtl/locality_pkg.sv]
// Summary of operation
// - A write of one to a use request sets it for that locality only.
// - A use request already set ignores further writes of one.
// - Granting a locality clears its use request.
// - A pending locality writing one to its granted flag cancels its request.
// - Writing zero to a use request does nothing.
// - With access valid set, the launch flag reads its true value.
// - With access valid clear, the launch flag reads zero or its true one.
// - After launch finish the flag stays zero until a clear launch write.
// - The launch flag lives in non-volatile storage across resets.
// - The launch flag reads one while no launch finish ever ran.
// - A launch finish clears a set launch flag promptly.
// - One launch flag shows identically at every locality.
// - A status write with more than one bit set is discarded whole.
// - Zero bits in a status write are no request.
// - First command byte after Ready enters Reception until execute trigger.
// - Execute trigger enters Execution until a response is pending.
// - Completion holds until software writes command ready.
// - Idle follows completion ready, locality change, abort, or init.
// - Ready state exactly while command ready reads set.
// - Command ready prepares when idle, aborts execution, frees on completion.
// - Status reads wait until non-qualified fields are true.
// - Status fields valid never reads one while qualified fields are unsettled.
// - Clear launch write works only from locality 3 or 4; reads zero.
// - Active locality writing its granted flag gives up control.
package locality_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          NUM_LOC     = 5;
  localparam logic [2:0]  LOC_NONE    = 3'h7;
  localparam logic [2:0]  LOC_LAUNCH  = 3'h3;
  localparam logic [7:0]  ACC_BASE    = 8'h00;
  localparam logic [7:0]  STS_BASE    = 8'h20;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Access register fields
  localparam int ACC_LAUNCH  = 0;
  localparam int ACC_REQUEST = 1;
  localparam int ACC_GRANTED = 5;
  localparam int ACC_VALID   = 7;
  // Status register fields
  localparam int STS_CLEAR   = 25;
  localparam int STS_FVALID  = 7;
  localparam int STS_READY   = 6;
  localparam int STS_GO      = 5;
  localparam int STS_PENDING = 4;
  localparam int STS_EXPECT  = 3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_READY = 5'b00010,
    ST_RECV  = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_DONE  = 5'b10000
  } cmd_state_type;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_type;

endpackage : locality_pkg

// [sim/nv_launch_store.sv]
`timescale 1ns/1ps
module nv_launch_store (
  input  wire logic clk,
  input  wire logic nvWrite,
  input  wire logic nvData,
  output      logic nvLaunchFlag
);
  // Blank store: no launch finish has ever run
  initial nvLaunchFlag = 1'b1;
  // No reset input, so the stored value outlives device resets
  always @(posedge clk) begin
    if (nvWrite === 1'b1) nvLaunchFlag <= nvData;
  end
endmodule : nv_launch_store

// [sim/test_locality_request_and_status_fsm.sv]
`timescale 1ns/1ps
module test_locality_request_and_status_fsm;
  import locality_pkg::*;
  logic         clk, reset_n, cmdByteWrite, execDone, cmdExpect;
  logic         fieldsSettled, launchFinish, nvLaunchFlag;
  logic         nvWrite, nvData, abortCmd, freeResources;
  logic [2:0]   activeLoc;
  axil_req_type axiReq;
  axil_rsp_type axiRsp;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           errors, checked, nAbort, nFree;

  locality_request_and_status_fsm locality_request_and_status_fsm_i (
    .clk(clk), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .cmdByteWrite(cmdByteWrite), .execDone(execDone),
    .cmdExpect(cmdExpect), .fieldsSettled(fieldsSettled),
    .launchFinish(launchFinish), .nvLaunchFlag(nvLaunchFlag),
    .nvWrite(nvWrite), .nvData(nvData), .abortCmd(abortCmd),
    .freeResources(freeResources), .activeLoc(activeLoc));
  nv_launch_store nv_launch_store_i (
    .clk(clk), .nvWrite(nvWrite), .nvData(nvData),
    .nvLaunchFlag(nvLaunchFlag));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (abortCmd === 1'b1) nAbort++;
    if (freeResources === 1'b1) nFree++;
  end

  task automatic report_and_stop();
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic stuck();
    errors++;
    report_and_stop();
  endtask : stuck

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  function automatic logic [7:0] acc(input int l);
    return ACC_BASE + 8'(4 * l);
  endfunction : acc

  function automatic logic [7:0] sts(input int l);
    return STS_BASE + 8'(4 * l);
  endfunction : sts

  task automatic wr(input logic [7:0]  a,
                    input logic [31:0] d,
                    input logic [3:0]  s = 4'hF);
    int n;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= s;
    axiReq.bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid === 1'b1) break;
    end
    if (n == 40) stuck();
    rs = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (axiReq.arvalid && axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1) break;
    end
    if (n == 40) stuck();
    rd = axiRsp.rdata;
    rs = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : rdw

  task automatic bit_wr(input logic [7:0] a, input int b);
    wr(a, 32'h1 << b);
    chk(rs, RESP_OKAY);
  endtask : bit_wr

  task automatic t_boot();
    rdw(8'h40);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h40, 32'h2);
    chk(rs, RESP_SLVERR);
    for (int l = 0; l < NUM_LOC; l++) begin
      rdw(acc(l));
      chk(rd[ACC_VALID], 1'b1);
      chk(rd[ACC_LAUNCH], 1'b1);
    end
    rdw(sts(0));
    chk(rd[STS_READY], 1'b0);
  endtask : t_boot

  task automatic t_request();
    bit_wr(acc(1), ACC_REQUEST);
    rdw(acc(1));
    chk(rd[ACC_GRANTED], 1'b1);
    chk(rd[ACC_REQUEST], 1'b0);
    bit_wr(acc(2), ACC_REQUEST);
    rdw(acc(0));
    chk(rd[ACC_REQUEST], 1'b0);
    bit_wr(acc(2), ACC_REQUEST);
    wr(acc(2), 32'h0);
    // Granted bit sits in the unstrobed lane, so this must not cancel
    wr(acc(2), 32'h20, 4'hE);
    rdw(acc(2));
    chk(rd[ACC_REQUEST], 1'b1);
    bit_wr(acc(2), ACC_GRANTED);
    rdw(acc(2));
    chk(rd[ACC_REQUEST], 1'b0);
    chk(activeLoc, 3'h1);
    bit_wr(acc(0), ACC_REQUEST);
    bit_wr(acc(1), ACC_GRANTED);
    rdw(acc(1));
    chk(rd[ACC_GRANTED], 1'b0);
    chk(activeLoc, 3'h0);
  endtask : t_request

  task automatic t_cmd();
    wr(sts(0), 32'h60);
    bit_wr(sts(2), STS_READY);
    rdw(sts(0));
    chk(rd[STS_READY], 1'b0);
    bit_wr(sts(0), STS_READY);
    rdw(sts(0));
    chk(rd[STS_READY], 1'b1);
    cmdByteWrite <= 1'b1;
    cmdExpect    <= 1'b1;
    @(posedge clk);
    cmdByteWrite <= 1'b0;
    rdw(sts(0));
    chk(rd[7:3], 5'b10001);
    fieldsSettled <= 1'b0;
    rdw(sts(0));
    chk(rd[STS_FVALID], 1'b0);
    fieldsSettled <= 1'b1;
    cmdExpect     <= 1'b0;
    rdw(sts(0));
    chk(rd[7:3], 5'b10000);
    bit_wr(sts(0), STS_GO);
    rdw(sts(0));
    chk(rd[6:4], 3'b000);
    execDone <= 1'b1;
    @(posedge clk);
    execDone <= 1'b0;
    wr(sts(0), 32'h0);
    rdw(sts(0));
    chk(rd[STS_PENDING], 1'b1);
    bit_wr(sts(0), STS_READY);
    rdw(sts(0));
    chk(rd[6:4], 3'b000);
    chk(nFree, 1);
    bit_wr(sts(0), STS_READY);
    cmdByteWrite <= 1'b1;
    @(posedge clk);
    cmdByteWrite <= 1'b0;
    bit_wr(sts(0), STS_GO);
    bit_wr(sts(0), STS_READY);
    rdw(sts(0));
    chk(rd[STS_READY], 1'b0);
    chk(nAbort, 1);
    bit_wr(sts(0), STS_READY);
    bit_wr(acc(3), ACC_REQUEST);
    bit_wr(acc(0), ACC_GRANTED);
    rdw(sts(3));
    chk(rd[STS_READY], 1'b0);
  endtask : t_cmd

  task automatic t_launch();
    launchFinish <= 1'b1;
    @(posedge clk);
    launchFinish <= 1'b0;
    rdw(acc(4));
    chk(rd[ACC_LAUNCH], 1'b0);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdw(acc(0));
    chk(rd[ACC_LAUNCH], 1'b0);
    chk(activeLoc, LOC_NONE);
    bit_wr(acc(0), ACC_REQUEST);
    bit_wr(sts(0), STS_CLEAR);
    rdw(acc(0));
    chk(rd[ACC_LAUNCH], 1'b0);
    bit_wr(acc(4), ACC_REQUEST);
    bit_wr(acc(0), ACC_GRANTED);
    bit_wr(sts(4), STS_CLEAR);
    rdw(acc(2));
    chk(rd[ACC_LAUNCH], 1'b1);
    rdw(sts(4));
    chk(rd[STS_CLEAR], 1'b0);
  endtask : t_launch

  initial begin
    errors = 0;
    checked = 0;
    nAbort = 0;
    nFree = 0;
    axiReq = '0;
    reset_n = 1'b0;
    cmdByteWrite = 1'b0;
    execDone = 1'b0;
    cmdExpect = 1'b0;
    fieldsSettled = 1'b1;
    launchFinish = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_boot();
    t_request();
    t_cmd();
    t_launch();
    report_and_stop();
  end
endmodule : test_locality_request_and_status_fsm
